// [verilog/adc_setup_average_reset_regs.sv]
// serial command decoder with setup, averaging and reset registers
`timescale 1ns/1ps
`default_nettype none
module adc_setup_average_reset_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic din,
    output logic [7:0] clock_reference_setup,
    output logic [7:0] averaging_scan_count,
    output logic [7:0] fifo_or_full_reset,
    output logic fifo_clear,
    output logic conversion_byte_valid,
    output logic [7:0] conversion_byte,
    output adc_cmd_pkg::config_s cfg
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    adc_cmd_pkg::serial_in_s pins;

    sync2 u_sync_sclk (
        .clk(clk),
        .rst_b(rst_b),
        .d(sclk),
        .q(pins.sclk)
    );

    // chip select resets to its idle level, no false frame start
    sync2 #(.RESET_VALUE(1'b1)) u_sync_cs (
        .clk(clk),
        .rst_b(rst_b),
        .d(cs_b),
        .q(pins.cs_b)
    );

    sync2 u_sync_din (
        .clk(clk),
        .rst_b(rst_b),
        .d(din),
        .q(pins.din)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic sclk_last;
        logic cs_last;
        logic [7:0] shift;
        logic [3:0] bit_count;
        logic byte_done;
        logic [7:0] setup;
        logic [7:0] average;
        logic [7:0] reset_reg;
        logic fifo_clear;
        logic conv_valid;
        logic [7:0] conv_byte;
    } state_s;

    state_s st;
    state_s next_st;
    logic sclk_rise;
    logic [7:0] full_byte;
    logic [1:0] ck;
    logic [1:0] rf;
    logic [1:0] depth;
    logic [1:0] count;

    assign sclk_rise = pins.sclk && !st.sclk_last;
    assign full_byte = {st.shift[6:0], pins.din};

    // ------------------------------------------------------------
    // shifter and decoder
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.sclk_last = pins.sclk;
        next_st.cs_last = pins.cs_b;
        next_st.fifo_clear = 1'b0;
        next_st.conv_valid = 1'b0;
        if (pins.cs_b) begin
            next_st.bit_count = 4'h0;
            next_st.byte_done = 1'b0;
        end else if (st.cs_last) begin
            next_st.bit_count = 4'h0;
            next_st.byte_done = 1'b0;
        end else if (sclk_rise && !st.byte_done) begin
            next_st.shift = full_byte;
            next_st.bit_count = st.bit_count + 4'h1;
            if (st.bit_count == 4'h7) begin
                next_st.byte_done = 1'b1;
                if (full_byte[7]) begin
                    next_st.conv_valid = 1'b1;
                    next_st.conv_byte = full_byte;
                end else if (full_byte[6]) begin
                    next_st.setup = {2'h1, full_byte[5:2], 2'h0};
                end else if (full_byte[5]) begin
                    next_st.average = full_byte;
                end else if (full_byte[4]) begin
                    next_st.reset_reg = {4'h1, full_byte[3], 3'h0};
                    if (full_byte[adc_cmd_pkg::RESET_KIND]) begin
                        next_st.fifo_clear = 1'b1;
                    end else begin
                        next_st.setup = adc_cmd_pkg::SETUP_RESET;
                        next_st.average = adc_cmd_pkg::AVG_RESET;
                        next_st.conv_byte = 8'h00;
                        next_st.fifo_clear = 1'b1;
                    end
                end
                // upper nibble zero: nothing written
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.cs_last <= 1'b1;
            st.setup <= adc_cmd_pkg::SETUP_RESET;
            st.average <= adc_cmd_pkg::AVG_RESET;
            st.reset_reg <= 8'h10;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    assign ck = {st.setup[adc_cmd_pkg::CK_HI], st.setup[adc_cmd_pkg::CK_LO]};
    assign rf = {st.setup[adc_cmd_pkg::REF_HI], st.setup[adc_cmd_pkg::REF_LO]};
    assign depth = {st.average[adc_cmd_pkg::DEPTH_HI], st.average[adc_cmd_pkg::DEPTH_LO]};
    assign count = {st.average[adc_cmd_pkg::COUNT_HI], st.average[adc_cmd_pkg::COUNT_LO]};

    always_comb begin
        cfg = '0;
        cfg.clock_mode = ck;
        cfg.reference_mode = rf;
        case (ck)
            adc_cmd_pkg::CK_CONVERT_START_PIN: begin
                cfg.internal_clock = 1'b1;
                cfg.internal_acq = 1'b1;
                cfg.convert_start_pin_starts = 1'b1;
            end
            adc_cmd_pkg::CK_EXT_ACQ: begin
                cfg.internal_clock = 1'b1;
                cfg.convert_start_pin_times_acq = 1'b1;
                cfg.convert_start_pin_starts = 1'b1;
            end
            adc_cmd_pkg::CK_SERIAL: begin
                cfg.internal_clock = 1'b1;
                cfg.internal_acq = 1'b1;
            end
            default: begin
                cfg.sclk_timed = 1'b1;
            end
        endcase
        case (rf)
            adc_cmd_pkg::REF_INT_AUTO: begin
                cfg.internal_ref = 1'b1;
                cfg.ref_off_after_scan = 1'b1;
                cfg.wakeup_delay = 1'b1;
            end
            adc_cmd_pkg::REF_EXT: begin
                cfg.internal_ref = 1'b0;
            end
            adc_cmd_pkg::REF_INT_ON: begin
                cfg.internal_ref = 1'b1;
                cfg.ref_always_on = 1'b1;
            end
            default: begin
                cfg.internal_ref = 1'b0; // reserved encoding
            end
        endcase
        cfg.averaging_active = st.average[adc_cmd_pkg::AVG_EN] && (ck != adc_cmd_pkg::CK_SCLK);
        if (!cfg.averaging_active) begin
            cfg.conversions_per_result = 6'h01;
        end else begin
            case (depth)
                2'h0: cfg.conversions_per_result = 6'h04;
                2'h1: cfg.conversions_per_result = 6'h08;
                2'h2: cfg.conversions_per_result = 6'h10;
                default: cfg.conversions_per_result = 6'h20;
            endcase
        end
        case (count)
            2'h0: cfg.single_channel_results = 5'h04;
            2'h1: cfg.single_channel_results = 5'h08;
            2'h2: cfg.single_channel_results = 5'h0c;
            default: cfg.single_channel_results = 5'h10;
        endcase
    end

    assign clock_reference_setup = st.setup;
    assign averaging_scan_count = st.average;
    assign fifo_or_full_reset = st.reset_reg;
    assign fifo_clear = st.fifo_clear;
    assign conversion_byte_valid = st.conv_valid;
    assign conversion_byte = st.conv_byte;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence last_bit_s;
        !pins.cs_b && !st.cs_last && sclk_rise && !st.byte_done && st.bit_count == 4'h7;
    endsequence

    setup_write_a: assert property (last_bit_s and (full_byte[7:6] == 2'h1)
        |=> st.setup[5:2] == $past(full_byte[5:2])) else $error("setup not written");
    avg_write_a: assert property (last_bit_s and (full_byte[7:5] == 3'h1)
        |=> st.average == $past(full_byte)) else $error("averaging not written");
    full_reset_a: assert property (last_bit_s and (full_byte[7:3] == 5'h02)
        |=> st.setup == 8'h60 && st.average == 8'h20 && fifo_clear
        && conversion_byte == 8'h00) else $error("no full reset");
    fifo_only_a: assert property (last_bit_s and (full_byte[7:3] == 5'h03)
        |=> fifo_clear && $stable(st.setup) && $stable(st.average)) else $error("fifo clear bad");
    conv_priority_a: assert property (last_bit_s and full_byte[7]
        |=> conversion_byte_valid && $stable(st.setup) && $stable(st.average)) else $error("conv priority");
    idle_byte_a: assert property (last_bit_s and (full_byte[7:4] == 4'h0)
        |=> $stable(st.setup) && $stable(st.average) && !fifo_clear) else $error("null byte acted");
    no_avg_sclk_a: assert property (ck == 2'h3 |-> !cfg.averaging_active
        && cfg.conversions_per_result == 6'h01) else $error("averaging in mode 11");
    depth_map_a: assert property (cfg.averaging_active |-> cfg.conversions_per_result
        == (6'h04 << depth)) else $error("bad depth");
    count_map_a: assert property (cfg.single_channel_results
        == {count, 2'h0} + 5'h04) else $error("bad scan count");
    ref_auto_a: assert property (rf == 2'h0 |-> cfg.wakeup_delay && cfg.internal_ref)
        else $error("reference 00 wrong");
endmodule : adc_setup_average_reset_regs
`default_nettype wire

// [include/adc_cmd_pkg.sv]
// constants and carrier types for the converter command decoder
package adc_cmd_pkg;
    localparam int CMD_BITS = 8;
    localparam logic [7:0] SETUP_RESET = 8'h60;
    localparam logic [7:0] AVG_RESET = 8'h20;
    localparam int CK_HI = 5;
    localparam int CK_LO = 4;
    localparam int REF_HI = 3;
    localparam int REF_LO = 2;
    localparam int AVG_EN = 4;
    localparam int DEPTH_HI = 3;
    localparam int DEPTH_LO = 2;
    localparam int COUNT_HI = 1;
    localparam int COUNT_LO = 0;
    localparam int RESET_KIND = 3;
    localparam int SCLK_MAX_KHZ = 4800;
    localparam logic [1:0] CK_CONVERT_START_PIN = 2'h0;
    localparam logic [1:0] CK_EXT_ACQ = 2'h1;
    localparam logic [1:0] CK_SERIAL = 2'h2;
    localparam logic [1:0] CK_SCLK = 2'h3;
    localparam logic [1:0] REF_INT_AUTO = 2'h0;
    localparam logic [1:0] REF_EXT = 2'h1;
    localparam logic [1:0] REF_INT_ON = 2'h2;

    typedef struct packed {
        logic sclk;
        logic cs_b;
        logic din;
    } serial_in_s;

    typedef struct packed {
        logic [1:0] clock_mode;
        logic internal_clock;
        logic internal_acq;
        logic convert_start_pin_starts;
        logic convert_start_pin_times_acq;
        logic sclk_timed;
        logic [1:0] reference_mode;
        logic internal_ref;
        logic ref_always_on;
        logic ref_off_after_scan;
        logic wakeup_delay;
        logic averaging_active;
        logic [5:0] conversions_per_result;
        logic [4:0] single_channel_results;
    } config_s;
endpackage : adc_cmd_pkg

// [verilog/sync2.sv]
// two flip-flop synchroniser, one bit
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);
    logic [1:0] stage;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage <= {2{RESET_VALUE}};
        end else begin
            stage <= {stage[0], d};
        end
    end

    assign q = stage[1];
endmodule : sync2
`default_nettype wire

// [tb/spi_host.sv]
// serial host model driving chip select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    input wire logic clk,
    input wire logic slow,
    output logic sclk,
    output logic cs_b,
    output logic din
);
    logic busy = 1'b0;
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        din = 1'b0;
    end
    // idle data line never holds the last bit
    always @(posedge clk) begin
        if (!busy) din <= ~din;
    end
    task automatic send(input logic [7:0] b, input int n);
        busy = 1'b1;
        @(posedge clk);
        cs_b <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            din <= (i < 8) ? b[7 - i] : 1'($urandom);
            repeat (slow ? 27 : 15 + (i % 4 == 3)) @(posedge clk);
            sclk <= 1'b1;
            repeat (slow ? 27 : 16) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_b <= 1'b1;
        busy = 1'b0;
    endtask : send
endmodule : spi_host
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic slow = 1'b0;
    logic sclk, cs_b, din, fclr, cvalid;
    logic [7:0] setup_q, avg_q, rst_q, conv_q;
    adc_cmd_pkg::config_s cfg;
    int num_errors = 0;
    int samples_checked = 0;
    logic [33:0] notes[$];
    logic [23:0] prev;
    logic [7:0] m_s = 8'h60, m_a = 8'h20, m_r = 8'h10, m_c = 8'h00;

    always #2 clk = ~clk;

    spi_host host (.clk(clk), .slow(slow), .sclk(sclk), .cs_b(cs_b), .din(din));
    adc_setup_average_reset_regs DUT (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din),
        .clock_reference_setup(setup_q), .averaging_scan_count(avg_q),
        .fifo_or_full_reset(rst_q), .fifo_clear(fclr), .conversion_byte_valid(cvalid),
        .conversion_byte(conv_q), .cfg(cfg)
    );

    task automatic check(input string what, input logic [33:0] e, input logic [33:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask : check

    function automatic logic [24:0] cfg_exp(input logic [7:0] s, input logic [7:0] a);
        logic [1:0] ck, rf;
        logic av;
        ck = s[5:4];
        rf = s[3:2];
        av = a[4] && ck != 2'h3;
        return {ck, ck != 2'h3, !ck[0], !ck[1], ck == 2'h1, ck == 2'h3, rf,
                rf == 2'h0 || rf == 2'h2, rf == 2'h2, rf == 2'h0, rf == 2'h0, av,
                av ? 6'h4 << a[3:2] : 6'h1, 5'({a[1:0], 2'h0}) + 5'h4};
    endfunction : cfg_exp

    task automatic chk_cfg();
        logic [24:0] got;
        got = {cfg.clock_mode, cfg.internal_clock, cfg.internal_acq, cfg.convert_start_pin_starts,
               cfg.convert_start_pin_times_acq, cfg.sclk_timed, cfg.reference_mode, cfg.internal_ref,
               cfg.ref_always_on, cfg.ref_off_after_scan, cfg.wakeup_delay,
               cfg.averaging_active, cfg.conversions_per_result, cfg.single_channel_results};
        check("cfg", 34'(cfg_exp(m_s, m_a)), 34'(got));
    endtask : chk_cfg

    task automatic cmd(input logic [7:0] b, input int n);
        logic fc, cv;
        logic [23:0] old;
        fc = 1'b0;
        cv = 1'b0;
        old = {m_s, m_a, m_r};
        slow <= m_s[5:4] == 2'h3;
        if (n >= 8) begin
            if (b[7]) begin
                m_c = b;
                cv = 1'b1;
            end else if (b[6]) m_s = b & 8'hfc;
            else if (b[5]) m_a = b;
            else if (b[4]) begin
                fc = 1'b1;
                m_r = b & 8'hf8;
                if (!b[3]) begin
                    m_s = 8'h60;
                    m_a = 8'h20;
                    m_c = 8'h00;
                end
            end
        end
        if (fc || cv || {m_s, m_a, m_r} != old) notes.push_back({m_s, m_a, m_r, fc, cv, m_c});
        host.send(b, n);
        repeat (10) @(posedge clk);
        chk_cfg();
    endtask : cmd

    // ------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst_b && (fclr || cvalid || {setup_q, avg_q, rst_q} !== prev)) begin
            if (notes.size() == 0) begin
                check("stray", 34'h0, {setup_q, avg_q, rst_q, 2'h3, conv_q});
            end else begin
                check("result", notes.pop_front(),
                      {setup_q, avg_q, rst_q, fclr, cvalid, conv_q});
            end
        end
        prev = {setup_q, avg_q, rst_q};
    end

    task automatic pulse_reset(input int n);
        rst_b <= 1'b0;
        repeat (n) @(posedge clk);
        rst_b <= 1'b1;
        {m_s, m_a, m_r, m_c} = {8'h60, 8'h20, 8'h10, 8'h00};
        repeat (4) @(posedge clk);
        check("reset", {8'h60, 8'h20, 8'h10, 10'h0},
              {setup_q, avg_q, rst_q, fclr, cvalid, conv_q});
        chk_cfg();
    endtask : pulse_reset

    task automatic wrap_up();
        if (notes.size() != 0) num_errors++;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hbc4c507a));
        pulse_reset(16);
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 3; r++)
                cmd(8'(32'h40 | (c << 4) | (r << 2) | ($urandom & 3)), 8);
        for (int i = 0; i < 64; i++) begin
            if (i == 0) cmd(8'h68, 8);
            if (i == 32) cmd(8'h74, 8);
            cmd(8'(32'h20 | (i & 31)), 8);
        end
        pulse_reset(3);
        repeat (6) cmd(8'(32'h80 | $urandom), 8);
        cmd(8'($urandom & 32'h0f), 8);
        cmd(8'h54, 5);
        cmd(8'h44, 16);
        cmd(8'(32'h18 | ($urandom & 7)), 8);
        cmd(8'h3f, 8);
        cmd(8'(32'h10 | ($urandom & 7)), 8);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
